// file: ioct_map.svh
`ifndef IOCT_MAP_SVH
`define IOCT_MAP_SVH
// ----------------------------------------------------------------------
// address map and timing
// ----------------------------------------------------------------------
`define IOCT_IO_BASE      32'h0000_0000
`define IOCT_IO_MASK      32'hFFFF_0000
`define IOCT_TRICK_BASE   32'h0000_0F00
`define IOCT_TRICK_MASK   32'hFFFF_FFF0
`define IOCT_STROBE_CYC   4'h6
`define IOCT_TRICK_DLY    2'h2
`define IOCT_TRICK_RST    16'h0000
`endif

// file: ioct_pkg.sv
`default_nettype none
package ioct_pkg;
  typedef enum logic [2:0] {
    IOCT_IDLE  = 3'b000,
    IOCT_RD    = 3'b001,
    IOCT_RDEND = 3'b010,
    IOCT_WR    = 3'b011,
    IOCT_DONE  = 3'b100
  } ioct_state_e;
endpackage : ioct_pkg
`default_nettype wire

// file: ioct_trick_regs.sv
`default_nettype none
`include "ioct_map.svh"
module ioct_trick_regs #(
  parameter int NREG = 16
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wr_pulse,
  input  wire logic [3:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  input  wire logic [3:0]  rd_idx,
  output logic      [15:0] rd_data
);
  // ----------------------------------------------------------------------
  // capture then commit two cycles after the pulse
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  pend;
    logic [3:0]  idx;
    logic [15:0] dat;
  } ioct_trk_s;
  ioct_trk_s   s_reg;
  ioct_trk_s   s_next;
  logic [15:0] mem [NREG];

  // pipeline for the delayed commit
  always_comb begin
    s_next      = s_reg;
    s_next.pend = {s_reg.pend[0], wr_pulse};
    if (wr_pulse) begin
      s_next.idx = wr_idx;
      s_next.dat = wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // register array, one generate entry each
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        mem[g] <= `IOCT_TRICK_RST;
      end else if (s_reg.pend[1] && s_reg.idx == 4'(g)) begin
        mem[g] <= s_reg.dat;
      end
    end
  end

  assign rd_data = mem[rd_idx];
endmodule : ioct_trick_regs
`default_nettype wire

// file: ioct_io_cycle.sv
// How it works
// - test registers decoded inside legacy io space
// - cpu io read asserts read strobe
// - io data copied to both buffer halves
// - buffered data driven to cpu during read
// - latch closes, then strobe negates next clock
// - latch holds only the low buffer half
// - upper half stays transparent, undefined
// - one-cycle write pulse in the clock after the last strobe cycle
// - write pulse stays internal
// - register takes data two clocks after pulse
`default_nettype none
`include "ioct_map.svh"
module ioct_io_cycle #(
  parameter logic [3:0] STROBE_CYC = `IOCT_STROBE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        cpu_req,
  input  wire logic        cpu_write,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [31:0] cpu_wdata,
  output logic      [31:0] cpu_rdata,
  output logic             cpu_rdata_oe,
  output logic             cpu_ack,
  output logic             io_rd_n,
  output logic             io_wr_n,
  output logic      [15:0] io_addr,
  input  wire logic [15:0] io_d_in,
  output logic      [15:0] io_d_out,
  output logic             io_d_oe,
  output logic             io_latw_n
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    ioct_pkg::ioct_state_e st;
    logic [3:0]            cnt;
    logic                  trick;
    logic                  latw_n;
    logic                  rd_n;
    logic                  wr_n;
    logic                  oe;
    logic                  ack;
    logic                  d_oe;
    logic [15:0]           lo;
    logic [15:0]           hi;
    logic [15:0]           addr;
    logic [15:0]           wdat;
    logic                  twr;
  } ioct_io_s;

  ioct_io_s    s_reg;
  ioct_io_s    s_next;
  logic        in_io;
  logic        in_trick;
  logic [15:0] trick_rd;

  // address decode; test registers sit inside the io window
  assign in_io    = (cpu_addr & `IOCT_IO_MASK) == `IOCT_IO_BASE;
  assign in_trick = (cpu_addr & `IOCT_TRICK_MASK) == `IOCT_TRICK_BASE;

  // ----------------------------------------------------------------------
  // internal test registers
  // ----------------------------------------------------------------------
  ioct_trick_regs #(
    .NREG (16)
  ) u_trick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_pulse (s_reg.twr),
    .wr_idx   (s_reg.addr[3:0]),
    .wr_data  (s_reg.wdat),
    .rd_idx   (s_reg.addr[3:0]),
    .rd_data  (trick_rd)
  );

  // io cycle state machine
  always_comb begin
    s_next     = s_reg;
    s_next.ack = 1'b0;
    s_next.twr = 1'b0;
    // buffer: upper half always transparent
    s_next.hi = s_reg.trick ? trick_rd : io_d_in;
    if (!s_reg.latw_n) begin
      s_next.lo = s_reg.trick ? trick_rd : io_d_in;
    end
    case (s_reg.st)
      ioct_pkg::IOCT_IDLE: begin
        s_next.oe   = 1'b0;
        s_next.d_oe = 1'b0;
        if (cpu_req && in_io) begin
          s_next.trick = in_trick;
          s_next.addr  = cpu_addr[15:0];
          s_next.wdat  = cpu_wdata[15:0];
          s_next.cnt   = STROBE_CYC;
          if (cpu_write) begin
            s_next.st   = ioct_pkg::IOCT_WR;
            s_next.wr_n = 1'b0;
            s_next.d_oe = 1'b1;
          end else begin
            s_next.st     = ioct_pkg::IOCT_RD;
            s_next.rd_n   = 1'b0;
            s_next.latw_n = 1'b0;
            s_next.oe     = 1'b1;
          end
        end
      end
      ioct_pkg::IOCT_RD: begin
        s_next.cnt = s_reg.cnt - 4'h1;
        if (s_reg.cnt <= 4'h2) begin
          s_next.latw_n = 1'b1;
          s_next.st     = ioct_pkg::IOCT_RDEND;
        end
      end
      ioct_pkg::IOCT_RDEND: begin
        s_next.rd_n = 1'b1;
        s_next.ack  = 1'b1;
        s_next.st   = ioct_pkg::IOCT_DONE;
      end
      ioct_pkg::IOCT_WR: begin
        s_next.cnt = s_reg.cnt - 4'h1;
        if (s_reg.cnt == 4'h1) begin
          s_next.twr  = s_reg.trick;
          s_next.wr_n = 1'b1;
          s_next.ack  = 1'b1;
          s_next.st   = ioct_pkg::IOCT_DONE;
        end
      end
      ioct_pkg::IOCT_DONE: begin
        s_next.oe   = 1'b0;
        s_next.d_oe = 1'b0;
        s_next.st   = ioct_pkg::IOCT_IDLE;
      end
      default: begin
        s_next.st = ioct_pkg::IOCT_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg        <= '0;
      s_reg.st     <= ioct_pkg::IOCT_IDLE;
      s_reg.latw_n <= 1'b1;
      s_reg.rd_n   <= 1'b1;
      s_reg.wr_n   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign cpu_rdata    = {s_reg.hi, s_reg.lo};
  assign cpu_rdata_oe = s_reg.oe;
  assign cpu_ack      = s_reg.ack;
  assign io_rd_n      = s_reg.rd_n;
  assign io_wr_n      = s_reg.wr_n;
  assign io_addr      = s_reg.addr;
  assign io_d_out     = s_reg.wdat;
  assign io_d_oe      = s_reg.d_oe;
  assign io_latw_n    = s_reg.latw_n;
endmodule : ioct_io_cycle
`default_nettype wire

// file: ioct_io_cycle_sva.sv
`default_nettype none
module ioct_io_cycle_chk #(
  parameter logic [3:0] STROBE_CYC = 4'h6
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [31:0] cpu_rdata,
  input wire logic        cpu_rdata_oe,
  input wire logic        cpu_ack,
  input wire logic        io_rd_n,
  input wire logic        io_wr_n,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_d_in,
  input wire logic        io_d_oe,
  input wire logic        io_latw_n
);
  wire logic tr = io_addr[15:4] == 12'h0F0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rd_len_a: assert property ($fell(io_rd_n) |->
    !io_rd_n[*6] ##1 (io_rd_n && cpu_ack)) else $error("read strobe len");
  rd_drive_a: assert property ($fell(io_rd_n) |->
    cpu_rdata_oe && !io_latw_n) else $error("read drive missing");
  latch_ord_a: assert property ($rose(io_latw_n) && cpu_rdata_oe |->
    !io_rd_n ##1 io_rd_n) else $error("latch order");
  rd_copy_a: assert property (!io_latw_n && !$past(io_latw_n) && !tr
    |-> cpu_rdata == {2{$past(io_d_in)}}) else $error("halves differ");
  lo_hold_a: assert property (cpu_rdata_oe && io_latw_n
    && $past(io_latw_n) |-> $stable(cpu_rdata[15:0])) else $error("lo moved");
  hi_open_a: assert property (cpu_rdata_oe && io_latw_n && !tr
    |-> cpu_rdata[31:16] == $past(io_d_in)) else $error("hi not open");
  wr_len_a: assert property ($fell(io_wr_n) |->
    (io_d_oe && !io_wr_n)[*6] ##1 io_wr_n) else $error("write strobe len");
  wr_end_a: assert property ($rose(io_wr_n) |-> cpu_ack
    ##1 !io_d_oe) else $error("write end");
  ack_one_a: assert property (cpu_ack |=> !cpu_ack)
    else $error("ack too long");
  cover property ($rose(io_rd_n));
  cover property ($rose(io_wr_n) && tr);
  cover property (cpu_ack && cpu_rdata_oe && tr);
endmodule : ioct_io_cycle_chk
bind ioct_io_cycle ioct_io_cycle_chk #(.STROBE_CYC(STROBE_CYC)) u_chk (.*);
`default_nettype wire

// file: ioct_io_dev.sv
`default_nettype none
module ioct_io_dev (
  input wire logic        core_clk,
  input wire logic        io_rd_n,
  output var logic [15:0] io_d_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pat = 8'hA5;
  // low byte only while read strobe low, else floating pattern
  always @(posedge core_clk) begin
    pat <= ~pat;
    io_d_in <= !io_rd_n ? {pat, 8'h0F} : {pat, ~pat};
  end
endmodule : ioct_io_dev
`default_nettype wire

// file: ioct_io_cycle_tb.sv
`default_nettype none
module ioct_io_cycle_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 0, rst_n = 0, cpu_req = 0, cpu_write = 0;
  logic [31:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata, r;
  logic        cpu_rdata_oe, cpu_ack, io_rd_n, io_wr_n, io_d_oe, io_latw_n;
  logic [15:0] io_addr, io_d_in, io_d_out;
  int          mismatches = 0, total_checks = 0, n;
  always #10 core_clk = ~core_clk;
  ioct_io_cycle uut (.*);
  ioct_io_dev dev (.*);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task cyc(input logic w, input logic [31:0] a, d);
    int k;
    n = 0;
    k = 0;
    @(negedge core_clk);
    {cpu_req, cpu_write, cpu_addr, cpu_wdata} = {1'b1, w, a, d};
    @(negedge core_clk);
    cpu_req = 0;
    while (cpu_ack !== 1'b1 && k < 40) begin
      n += (!io_rd_n || !io_wr_n);
      k++;
      @(negedge core_clk);
    end
    r = cpu_rdata;
    chk("ack", 1, {31'h0, cpu_ack});
    repeat (2) @(negedge core_clk);
  endtask : cyc
  task t_rwr;
    cyc(0, 32'h0000_0300, 0);
    chk("rd len", 6, n);
    chk("rd byte", 8'h0F, r[7:0]);
    cyc(1, 32'h0000_0300, 32'h0000_BEEF);
    chk("wr len", 6, n);
    cyc(0, 32'h0000_0301, 0);
    chk("rd byte2", 8'h0F, r[7:0]);
  endtask : t_rwr
  task t_trick;
    cyc(1, 32'h0000_0F03, 32'h0000_1234);
    chk("tr strobe", 6, n);
    cyc(0, 32'h0000_0F03, 0);
    chk("tr data", 16'h1234, r[15:0]);
  endtask : t_trick
  task t_refuse;
    int bad;
    bad = 0;
    @(negedge core_clk);
    {cpu_req, cpu_write, cpu_addr} = {1'b1, 1'b0, 32'h0001_0300};
    repeat (20) begin
      @(negedge core_clk);
      bad += (cpu_ack !== 1'b0 || io_rd_n !== 1'b1);
    end
    cpu_req = 0;
    chk("refuse", 0, bad);
  endtask : t_refuse
  // main sequence
  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1;
    t_rwr();
    t_trick();
    t_refuse();
    report_and_stop();
  end
  // watchdog
  initial begin
    #100us;
    mismatches++;
    report_and_stop();
  end
endmodule : ioct_io_cycle_tb
`default_nettype wire
